// file: verilog/axis_switch_regs.vh
// register offsets, field positions and reset values of the axis mode-switch block
`ifndef AXIS_SWITCH_REGS_VH
`define AXIS_SWITCH_REGS_VH

// byte offsets on the register port
`define OFS_CMD          8'h00
`define OFS_AXIS         8'h04
`define OFS_SLOT         8'h08
`define OFS_START_CTRL   8'h0C
`define OFS_X_DIR_TGT    8'h10
`define OFS_Y_DIR_TGT    8'h14
`define OFS_X_STEP_TGT   8'h18
`define OFS_Y_STEP_TGT   8'h1C
`define OFS_STATUS       8'h20
`define OFS_X_POS        8'h24
`define OFS_Y_POS        8'h28
`define OFS_IRQ_STAT     8'h2C
`define OFS_IRQ_MASK     8'h30
`define OFS_RATE         8'h34

// command register: request levels, one action per rising edge
`define CMD_TO_POS_BIT   0
`define CMD_TO_SPEED_BIT 1
`define CMD_DIRECT_BIT   2
`define CMD_INDIRECT_BIT 3
`define CMD_STOP_BIT     4
`define CMD_W            5

// axis and slot operand codes
`define AXIS_X_CODE      16'h0000
`define AXIS_Y_CODE      16'h0001
`define SLOT_BASE_CODE   16'h0000

// start control fields
`define START_SPEED_BIT  0
`define START_REV_BIT    1

// status register fields
`define ST_X_SPEED_BIT   0
`define ST_X_POS_BIT     1
`define ST_X_ERR_BIT     2
`define ST_Y_SPEED_BIT   4
`define ST_Y_POS_BIT     5
`define ST_Y_ERR_BIT     6
`define ST_INSTR_ERR_BIT 8

// interrupt status / mask fields
`define IRQ_INSTR_BIT    0
`define IRQ_X_DONE_BIT   1
`define IRQ_Y_DONE_BIT   2
`define IRQ_X_SW_BIT     3
`define IRQ_Y_SW_BIT     4
`define IRQ_W            5

// reset values
`define CMD_RST          5'h00
`define OPERAND_RST      16'h0000
`define START_CTRL_RST   2'h0
`define TARGET_RST       32'h00000000
`define IRQ_MASK_RST     5'h00
`define RATE_RST         16'h0028
`define POS_ZERO         32'h00000000

`endif

// file: verilog/axis_motion.v
// one pulse-train axis: speed or position control with mode switching
`timescale 1ns/1ps
`default_nettype none
`include "axis_switch_regs.vh"

module axis_motion (
	input  wire        sys_clk,
	input  wire        reset_n,
	input  wire        startSpeed,
	input  wire        startPos,
	input  wire        switchToPos,
	input  wire        switchToSpeed,
	input  wire        stopAxis,
	input  wire        dirNeg,
	input  wire [31:0] newTarget,
	input  wire [15:0] rateDiv,
	output wire        speedCtrl,
	output wire        posCtrl,
	output reg  [31:0] position_r,
	output reg         pulse_r,
	output reg         dirNeg_r,
	output reg         reached_r
);
	localparam [1:0] MODE_IDLE  = 2'h0;
	localparam [1:0] MODE_SPEED = 2'h1;
	localparam [1:0] MODE_POS   = 2'h2;

	reg [1:0]  mode_r;
	reg [31:0] target_r;
	reg [15:0] divCnt_r;
	wire       tick = (divCnt_r >= rateDiv - 16'h0001);

	assign speedCtrl = (mode_r == MODE_SPEED);
	assign posCtrl   = (mode_r == MODE_POS);

	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			mode_r     <= MODE_IDLE;
			target_r   <= `TARGET_RST;
			divCnt_r   <= 16'h0000;
			position_r <= `POS_ZERO;
			pulse_r    <= 1'b0;
			dirNeg_r   <= 1'b0;
			reached_r  <= 1'b0;
		end else begin
			pulse_r   <= 1'b0;
			reached_r <= 1'b0;
			divCnt_r  <= (tick || mode_r == MODE_IDLE) ? 16'h0000 : divCnt_r + 16'h0001;
			if (stopAxis) begin
				mode_r <= MODE_IDLE;
			end else if (switchToPos && mode_r == MODE_SPEED) begin
				// position restarts from zero and the target is absolute from there
				position_r <= `POS_ZERO;
				target_r   <= newTarget;
				dirNeg_r   <= newTarget[31];
				mode_r     <= MODE_POS;
			end else if (switchToSpeed && mode_r == MODE_POS) begin
				// position and direction kept: only the control method changes
				mode_r <= MODE_SPEED;
			end else if (startSpeed && mode_r == MODE_IDLE) begin
				dirNeg_r <= dirNeg;
				mode_r   <= MODE_SPEED;
			end else if (startPos && mode_r == MODE_IDLE) begin
				target_r <= newTarget;
				dirNeg_r <= ($signed(newTarget) < $signed(position_r));
				mode_r   <= MODE_POS;
			end else if (tick) begin
				case (mode_r)
				MODE_POS: begin
					if (position_r == target_r) begin
						mode_r    <= MODE_IDLE;
						reached_r <= 1'b1;
					end else begin
						pulse_r    <= 1'b1;
						position_r <= dirNeg_r ? position_r - 32'h00000001 : position_r + 32'h00000001;
					end
				end
				MODE_SPEED: begin
					pulse_r    <= 1'b1;
					position_r <= dirNeg_r ? position_r - 32'h00000001 : position_r + 32'h00000001;
				end
				default: begin
					mode_r <= MODE_IDLE;
				end
				endcase
			end
		end
	end
endmodule // axis_motion

`default_nettype wire

// file: verilog/axis_control_mode_switch.v
// two-axis control-mode switching with register port, command decode and interrupt
`timescale 1ns/1ps
`default_nettype none
`include "axis_switch_regs.vh"

module axis_control_mode_switch (
	input  wire        sys_clk,
	input  wire        reset_n,
	input  wire [7:0]  regAddr,
	input  wire [31:0] regWrData,
	input  wire        regWrEn,
	input  wire        regRdEn,
	output reg  [31:0] regRdData,
	output wire        xPulse,
	output wire        xDir,
	output wire        yPulse,
	output wire        yDir,
	output wire        xSpeedCtrlFlag,
	output wire        ySpeedCtrlFlag,
	output wire        xPositionCtrlFlag,
	output wire        yPositionCtrlFlag,
	output wire        xAxisErrorFlag,
	output wire        yAxisErrorFlag,
	output wire        instrErrorFlag,
	output wire        irq
);
	// software-written registers and the previous command value
	reg [`CMD_W-1:0]  switchRequest_r;
	reg [`CMD_W-1:0]  switchRequestPrev_r;
	reg [15:0]        axisOperand_r;
	reg [15:0]        slotOperand_r;
	reg [1:0]         startCtrl_r;
	reg [31:0]        directTarget_r [0:1];
	reg [31:0]        stepTarget_r [0:1];
	reg [15:0]        rateDiv_r;
	reg [`IRQ_W-1:0]  irqMask_r;

	// block state
	reg [`IRQ_W-1:0]  irqStat_r;
	reg [`IRQ_W-1:0]  irqStat_nxt;
	reg               instrErr_r;
	reg               instrErr_nxt;
	reg [1:0]         axisErr_r;
	reg [1:0]         axisErr_nxt;
	reg [1:0]         startedDirect_r;
	reg [1:0]         startedDirect_nxt;

	// per-axis command pulses into the motion engines, the chosen target and decode errors
	reg [1:0]         goSwitchToPos;
	reg [1:0]         goSwitchToSpeed;
	reg [1:0]         goStartSpeed;
	reg [1:0]         goStartPos;
	reg [1:0]         goStop;
	reg [31:0]        axisTarget;
	reg               opError;
	reg [1:0]         modeMismatch;

	wire [`CMD_W-1:0] requestRise;
	wire              speedToPositionCmd;
	wire              positionToSpeedCmd;
	wire              directStartCmd;
	wire              indirectStartCmd;
	wire              stopCmd;
	wire              axisValid;
	wire              axisSel;
	wire              slotValid;
	wire [1:0]        speedCtrl;
	wire [1:0]        posCtrl;
	wire [1:0]        reached;
	wire [31:0]       xPosition;
	wire [31:0]       yPosition;
	wire [31:0]       targetX;
	wire [31:0]       targetY;
	wire [1:0]        switchDone;
	wire [`IRQ_W-1:0] irqEvents;
	wire              wrStatus;
	wire              wrIrqStat;
	wire [31:0]       statusWord;

	// each request is a level held in the command register; only its rising edge acts
	assign requestRise        = switchRequest_r & ~switchRequestPrev_r;
	assign speedToPositionCmd = requestRise[`CMD_TO_POS_BIT];
	assign positionToSpeedCmd = requestRise[`CMD_TO_SPEED_BIT];
	assign directStartCmd     = requestRise[`CMD_DIRECT_BIT];
	assign indirectStartCmd   = requestRise[`CMD_INDIRECT_BIT];
	assign stopCmd            = requestRise[`CMD_STOP_BIT];

	// operand check: only codes 0 and 1 name an axis
	assign axisValid = (axisOperand_r == `AXIS_X_CODE) || (axisOperand_r == `AXIS_Y_CODE);
	assign axisSel   = axisOperand_r[0];
	assign slotValid = (slotOperand_r == `SLOT_BASE_CODE);

	assign wrStatus  = regWrEn && (regAddr == `OFS_STATUS);
	assign wrIrqStat = regWrEn && (regAddr == `OFS_IRQ_STAT);

	// command decode
	always @* begin
		goSwitchToPos     = 2'b00;
		goSwitchToSpeed   = 2'b00;
		goStartSpeed      = 2'b00;
		goStartPos        = 2'b00;
		goStop            = 2'b00;
		opError           = 1'b0;
		modeMismatch      = 2'b00;
		startedDirect_nxt = startedDirect_r;
		if (|requestRise) begin
			if (!axisValid || !slotValid) begin
				// a bad operand refuses every command raised in this cycle
				opError = 1'b1;
			end else begin
				if (speedToPositionCmd) begin
					if (speedCtrl[axisSel]) begin
						goSwitchToPos[axisSel] = 1'b1;
					end else begin
						modeMismatch[axisSel] = 1'b1;
					end
				end
				if (positionToSpeedCmd) begin
					if (posCtrl[axisSel]) begin
						goSwitchToSpeed[axisSel] = 1'b1;
					end else begin
						modeMismatch[axisSel] = 1'b1;
					end
				end
				if (directStartCmd) begin
					goStartSpeed[axisSel]      = startCtrl_r[`START_SPEED_BIT];
					goStartPos[axisSel]        = ~startCtrl_r[`START_SPEED_BIT];
					startedDirect_nxt[axisSel] = 1'b1;
				end else if (indirectStartCmd) begin
					goStartSpeed[axisSel]      = startCtrl_r[`START_SPEED_BIT];
					goStartPos[axisSel]        = ~startCtrl_r[`START_SPEED_BIT];
					startedDirect_nxt[axisSel] = 1'b0;
				end
				if (stopCmd) begin
					goStop[axisSel] = 1'b1;
				end
			end
		end
	end

	// target handed to an axis: a fresh start takes the source of its own command,
	// a later switch takes the source of the last start command raised on that axis
	always @* begin
		axisTarget = stepTarget_r[axisSel];
		if (directStartCmd) begin
			axisTarget = directTarget_r[axisSel];
		end else if (indirectStartCmd) begin
			axisTarget = stepTarget_r[axisSel];
		end else if (startedDirect_r[axisSel]) begin
			axisTarget = directTarget_r[axisSel];
		end
	end

	assign targetX = axisSel ? stepTarget_r[0] : axisTarget;
	assign targetY = axisSel ? axisTarget : stepTarget_r[1];

	// error flags and interrupt status: a new event wins over a clear in the same cycle
	always @* begin
		instrErr_nxt = instrErr_r;
		axisErr_nxt  = axisErr_r;
		irqStat_nxt  = irqStat_r;
		if (wrStatus) begin
			if (regWrData[`ST_INSTR_ERR_BIT]) begin
				instrErr_nxt = 1'b0;
			end
			if (regWrData[`ST_X_ERR_BIT]) begin
				axisErr_nxt[0] = 1'b0;
			end
			if (regWrData[`ST_Y_ERR_BIT]) begin
				axisErr_nxt[1] = 1'b0;
			end
		end
		if (wrIrqStat) begin
			irqStat_nxt = irqStat_r & ~regWrData[`IRQ_W-1:0];
		end
		instrErr_nxt = instrErr_nxt | opError;
		axisErr_nxt  = axisErr_nxt | modeMismatch;
		irqStat_nxt  = irqStat_nxt | irqEvents;
	end

	assign switchDone = goSwitchToPos | goSwitchToSpeed;
	assign irqEvents  = {switchDone[1], switchDone[0], reached[1], reached[0], opError};
	assign irq        = |(irqStat_r & irqMask_r);

	// register writes
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			switchRequest_r     <= `CMD_RST;
			switchRequestPrev_r <= `CMD_RST;
			axisOperand_r       <= `OPERAND_RST;
			slotOperand_r       <= `OPERAND_RST;
			startCtrl_r         <= `START_CTRL_RST;
			directTarget_r[0]   <= `TARGET_RST;
			directTarget_r[1]   <= `TARGET_RST;
			stepTarget_r[0]     <= `TARGET_RST;
			stepTarget_r[1]     <= `TARGET_RST;
			rateDiv_r           <= `RATE_RST;
			irqMask_r           <= `IRQ_MASK_RST;
		end else begin
			switchRequestPrev_r <= switchRequest_r;
			if (regWrEn) begin
				case (regAddr)
				`OFS_CMD:        switchRequest_r   <= regWrData[`CMD_W-1:0];
				`OFS_AXIS:       axisOperand_r     <= regWrData[15:0];
				`OFS_SLOT:       slotOperand_r     <= regWrData[15:0];
				`OFS_START_CTRL: startCtrl_r       <= regWrData[1:0];
				`OFS_X_DIR_TGT:  directTarget_r[0] <= regWrData;
				`OFS_Y_DIR_TGT:  directTarget_r[1] <= regWrData;
				`OFS_X_STEP_TGT: stepTarget_r[0]   <= regWrData;
				`OFS_Y_STEP_TGT: stepTarget_r[1]   <= regWrData;
				`OFS_IRQ_MASK:   irqMask_r         <= regWrData[`IRQ_W-1:0];
				`OFS_RATE: begin
					// a zero divider would wrap to a 65536-cycle pulse period, so it is held at one
					rateDiv_r <= (regWrData[15:0] == 16'h0000) ? 16'h0001 : regWrData[15:0];
				end
				default: begin
					rateDiv_r <= rateDiv_r;
				end
				endcase
			end
		end
	end

	// sticky flags and the last start source per axis
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			instrErr_r      <= 1'b0;
			axisErr_r       <= 2'b00;
			irqStat_r       <= {`IRQ_W{1'b0}};
			startedDirect_r <= 2'b00;
		end else begin
			instrErr_r      <= instrErr_nxt;
			axisErr_r       <= axisErr_nxt;
			irqStat_r       <= irqStat_nxt;
			startedDirect_r <= startedDirect_nxt;
		end
	end

	assign statusWord = {23'h000000, instrErr_r,
		1'b0, axisErr_r[1], posCtrl[1], speedCtrl[1],
		1'b0, axisErr_r[0], posCtrl[0], speedCtrl[0]};

	// read data stand for exactly one cycle after the read strobe
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			regRdData <= 32'h00000000;
		end else if (regRdEn) begin
			case (regAddr)
			`OFS_CMD:        regRdData <= {27'h0000000, switchRequest_r};
			`OFS_AXIS:       regRdData <= {16'h0000, axisOperand_r};
			`OFS_SLOT:       regRdData <= {16'h0000, slotOperand_r};
			`OFS_START_CTRL: regRdData <= {30'h00000000, startCtrl_r};
			`OFS_X_DIR_TGT:  regRdData <= directTarget_r[0];
			`OFS_Y_DIR_TGT:  regRdData <= directTarget_r[1];
			`OFS_X_STEP_TGT: regRdData <= stepTarget_r[0];
			`OFS_Y_STEP_TGT: regRdData <= stepTarget_r[1];
			`OFS_STATUS:     regRdData <= statusWord;
			`OFS_X_POS:      regRdData <= xPosition;
			`OFS_Y_POS:      regRdData <= yPosition;
			`OFS_IRQ_STAT:   regRdData <= {27'h0000000, irqStat_r};
			`OFS_IRQ_MASK:   regRdData <= {27'h0000000, irqMask_r};
			`OFS_RATE:       regRdData <= {16'h0000, rateDiv_r};
			default:         regRdData <= 32'h00000000;
			endcase
		end else begin
			regRdData <= 32'h00000000;
		end
	end

	// X axis engine: position cleared on a switch into position control, kept on the way back
	axis_motion xAxis (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.startSpeed    (goStartSpeed[0]),
		.startPos      (goStartPos[0]),
		.switchToPos   (goSwitchToPos[0]),
		.switchToSpeed (goSwitchToSpeed[0]),
		.stopAxis      (goStop[0]),
		.dirNeg        (startCtrl_r[`START_REV_BIT]),
		.newTarget     (targetX),
		.rateDiv       (rateDiv_r),
		.speedCtrl     (speedCtrl[0]),
		.posCtrl       (posCtrl[0]),
		.position_r    (xPosition),
		.pulse_r       (xPulse),
		.dirNeg_r      (xDir),
		.reached_r     (reached[0])
	);

	// Y axis engine
	axis_motion yAxis (
		.sys_clk       (sys_clk),
		.reset_n       (reset_n),
		.startSpeed    (goStartSpeed[1]),
		.startPos      (goStartPos[1]),
		.switchToPos   (goSwitchToPos[1]),
		.switchToSpeed (goSwitchToSpeed[1]),
		.stopAxis      (goStop[1]),
		.dirNeg        (startCtrl_r[`START_REV_BIT]),
		.newTarget     (targetY),
		.rateDiv       (rateDiv_r),
		.speedCtrl     (speedCtrl[1]),
		.posCtrl       (posCtrl[1]),
		.position_r    (yPosition),
		.pulse_r       (yPulse),
		.dirNeg_r      (yDir),
		.reached_r     (reached[1])
	);

	// status pins mirror the register view
	assign xSpeedCtrlFlag    = speedCtrl[0];
	assign ySpeedCtrlFlag    = speedCtrl[1];
	assign xPositionCtrlFlag = posCtrl[0];
	assign yPositionCtrlFlag = posCtrl[1];
	assign xAxisErrorFlag    = axisErr_r[0];
	assign yAxisErrorFlag    = axisErr_r[1];
	assign instrErrorFlag    = instrErr_r;

endmodule // axis_control_mode_switch

`default_nettype wire

// file: test/motor_pulse_model.sv
// step counter standing in for the motor drives of both axes
`timescale 1ns/1ps
`default_nettype none
module motor_pulse_model (
	input  wire logic        sys_clk,
	input  wire logic        xPulse,
	input  wire logic        xDir,
	input  wire logic        yPulse,
	input  wire logic        yDir,
	output var  logic [31:0] xCnt,
	output var  logic [31:0] yCnt
);
	initial begin
		xCnt = 32'h00000000;
		yCnt = 32'h00000000;
	end
	// a drive has no idea of the block's zero point, so it only counts steps
	always @(posedge sys_clk) begin
		if (xPulse)
			xCnt <= xDir ? xCnt - 32'h00000001 : xCnt + 32'h00000001;
		if (yPulse)
			yCnt <= yDir ? yCnt - 32'h00000001 : yCnt + 32'h00000001;
	end
endmodule // motor_pulse_model
`default_nettype wire

// file: test/axis_control_mode_switch_sva.sv
// assertions on the ports of the axis mode-switch block
`timescale 1ns/1ps
`default_nettype none
`include "axis_switch_regs.vh"
module axis_control_mode_switch_sva (
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	input  wire logic [7:0]  regAddr,
	input  wire logic [31:0] regWrData,
	input  wire logic        regWrEn,
	input  wire logic        regRdEn,
	input  wire logic [31:0] regRdData,
	input  wire logic        xSpeedCtrlFlag,
	input  wire logic        ySpeedCtrlFlag,
	input  wire logic        xPositionCtrlFlag,
	input  wire logic        yPositionCtrlFlag,
	input  wire logic        xAxisErrorFlag,
	input  wire logic        yAxisErrorFlag,
	input  wire logic        instrErrorFlag,
	input  wire logic        irq
);
	logic [4:0]  cmd_r;
	logic [15:0] axis_r;
	logic [15:0] slot_r;
	logic [4:0]  mask_r;
	logic        cmdWr;
	logic        opsOk;
	assign cmdWr = regWrEn && regAddr == `OFS_CMD;
	assign opsOk = axis_r < 16'h0002 && slot_r == `SLOT_BASE_CODE;
	// shadows of what software wrote, so rising command bits can be told apart
	always @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cmd_r <= 5'h00;
			axis_r <= 16'h0000;
			slot_r <= 16'h0000;
			mask_r <= 5'h00;
		end else if (regWrEn) begin
			if (regAddr == `OFS_CMD) cmd_r <= regWrData[4:0];
			if (regAddr == `OFS_AXIS) axis_r <= regWrData[15:0];
			if (regAddr == `OFS_SLOT) slot_r <= regWrData[15:0];
			if (regAddr == `OFS_IRQ_MASK) mask_r <= regWrData[4:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	chk_rd_stands: assert property (!$past(regRdEn) |-> regRdData == 32'h00000000)
		else $error("read data seen outside the answer cycle");
	chk_to_pos_x: assert property (cmdWr && regWrData[0] && !cmd_r[0] && axis_r == `AXIS_X_CODE && opsOk
		&& xSpeedCtrlFlag |-> ##[2:3] (xPositionCtrlFlag && !xSpeedCtrlFlag))
		else $error("x axis did not enter position control");
	chk_to_speed_y: assert property (cmdWr && regWrData[1] && !cmd_r[1] && axis_r == `AXIS_Y_CODE && opsOk
		&& yPositionCtrlFlag |-> ##[2:3] (ySpeedCtrlFlag && !yPositionCtrlFlag))
		else $error("y axis did not enter speed control");
	chk_bad_operand: assert property (cmdWr && (regWrData[1:0] & ~cmd_r[1:0]) != 2'b00 && !opsOk
		|-> ##[2:3] instrErrorFlag)
		else $error("bad operand did not raise the instruction error");
	chk_bad_no_switch: assert property (cmdWr && (regWrData[1:0] & ~cmd_r[1:0]) != 2'b00 && !opsOk
		&& xSpeedCtrlFlag |-> ##1 xSpeedCtrlFlag [*3])
		else $error("switch done despite a bad operand");
	chk_held_once: assert property (cmdWr && (regWrData[4:0] & ~cmd_r) == 5'h00 && regWrData[1]
		&& ySpeedCtrlFlag && !yAxisErrorFlag |-> ##1 (ySpeedCtrlFlag && !yAxisErrorFlag) [*3])
		else $error("held request caused a second action");
	chk_modes_apart: assert property (!(xSpeedCtrlFlag && xPositionCtrlFlag) && !(ySpeedCtrlFlag && yPositionCtrlFlag))
		else $error("speed and position flags high together");
	chk_instr_sticky: assert property (instrErrorFlag
		&& !(regWrEn && regAddr == `OFS_STATUS && regWrData[8]) |=> instrErrorFlag)
		else $error("instruction error dropped without a clear");
	chk_axis_err_sticky: assert property (xAxisErrorFlag
		&& !(regWrEn && regAddr == `OFS_STATUS && regWrData[2]) |=> xAxisErrorFlag)
		else $error("axis error dropped without a clear");
	chk_irq_masked: assert property (mask_r == 5'h00 |-> !irq)
		else $error("interrupt high with every source masked");
endmodule // axis_control_mode_switch_sva
`default_nettype wire

// file: test/test_axis_control_mode_switch.sv
// self-checking bench for the axis mode-switch block
`timescale 1ns/1ps
`default_nettype none
`include "axis_switch_regs.vh"
module test_axis_control_mode_switch;
	typedef struct {logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_t;
	logic        sys_clk, reset_n, regWrEn, regRdEn;
	logic [7:0]  regAddr;
	logic [31:0] regWrData, regRdData, xCnt, yCnt, yBase, ySw;
	logic        xPulse, xDir, yPulse, yDir, xSpd, ySpd, xPos, yPos, xErr, yErr, instrErr, irq;
	int          errorCnt, totalChecks;
	row_t        rows [6] = '{'{`OFS_X_DIR_TGT, 32'hFFFFFFF6, 32'hFFFFFFF6}, '{`OFS_AXIS, 32'hFFFF0001, 32'h00000001},
		'{`OFS_START_CTRL, 32'h000000FF, 32'h00000003}, '{`OFS_RATE, 32'h00000000, 32'h00000001},
		'{`OFS_IRQ_MASK, 32'h000000FF, 32'h0000001F}, '{8'h3C, 32'h12345678, 32'h00000000}};
	axis_control_mode_switch uut (.sys_clk(sys_clk), .reset_n(reset_n), .regAddr(regAddr), .regWrData(regWrData),
		.regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .xPulse(xPulse), .xDir(xDir),
		.yPulse(yPulse), .yDir(yDir), .xSpeedCtrlFlag(xSpd), .ySpeedCtrlFlag(ySpd), .xPositionCtrlFlag(xPos),
		.yPositionCtrlFlag(yPos), .xAxisErrorFlag(xErr), .yAxisErrorFlag(yErr), .instrErrorFlag(instrErr), .irq(irq));
	motor_pulse_model drives (.sys_clk(sys_clk), .xPulse(xPulse), .xDir(xDir), .yPulse(yPulse), .yDir(yDir),
		.xCnt(xCnt), .yCnt(yCnt));
	always #12.5 sys_clk = ~sys_clk;
	task automatic wrapUp();
		$display("checks %0d mismatches %0d", totalChecks, errorCnt);
		if (errorCnt == 0 && totalChecks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			errorCnt++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// both bus tasks span two edges so a strobe is never lowered and raised in one step
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWrEn <= 1'b1;
		@(posedge sys_clk);
		regWrEn <= 1'b0;
		@(posedge sys_clk);
	endtask
	task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] e);
		regAddr <= a;
		regRdEn <= 1'b1;
		@(posedge sys_clk);
		regRdEn <= 1'b0;
		@(negedge sys_clk);
		check(what, regRdData, e);
		@(posedge sys_clk);
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic waitDone(input bit yAx);
		int n;
		n = 0;
		while ((yAx ? yPos : xPos) !== 1'b0 && n < 2000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 2000) begin
			check("position run end", 32'h1, 32'h0);
			wrapUp();
		end
	endtask
	initial begin
		sys_clk = 1'b0;
		reset_n = 1'b0;
		{regWrEn, regRdEn, regAddr, regWrData} = '0;
		idle(16);
		reset_n <= 1'b1;
		@(posedge sys_clk);
		rdChk("rate reset", `OFS_RATE, 32'h00000028);
		rdChk("status reset", `OFS_STATUS, 32'h00000000);
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].d);
			rdChk("register readback", rows[i].a, rows[i].e);
		end
		$display("register rows done");
		wr(`OFS_RATE, 32'h00000004);
		wr(`OFS_IRQ_MASK, 32'h00000000);
		wr(`OFS_AXIS, `AXIS_X_CODE);
		wr(`OFS_X_DIR_TGT, 32'h0000000A);
		wr(`OFS_START_CTRL, 32'h00000001);
		wr(`OFS_CMD, 32'h00000004);
		idle(3);
		check("x speed flag", xSpd, 1'b1);
		idle(40);
		wr(`OFS_CMD, 32'h00000000);
		wr(`OFS_CMD, 32'h00000001);
		idle(3);
		check("x position flag", {xPos, xSpd}, 2'b10);
		waitDone(1'b0);
		rdChk("x position after run", `OFS_X_POS, 32'h0000000A);
		rdChk("irq status", `OFS_IRQ_STAT, 32'h0000000A);
		check("irq masked", irq, 1'b0);
		wr(`OFS_IRQ_MASK, 32'h00000002);
		check("irq unmasked", irq, 1'b1);
		wr(`OFS_IRQ_STAT, 32'h0000000A);
		check("irq cleared", irq, 1'b0);
		$display("x direct switch done");
		wr(`OFS_Y_STEP_TGT, 32'h00000006);
		wr(`OFS_Y_DIR_TGT, 32'h00000064);
		wr(`OFS_AXIS, `AXIS_Y_CODE);
		wr(`OFS_CMD, 32'h00000008);
		idle(20);
		wr(`OFS_CMD, 32'h00000009);
		idle(3);
		check("y position flag", yPos, 1'b1);
		waitDone(1'b1);
		rdChk("y position after run", `OFS_Y_POS, 32'h00000006);
		wr(`OFS_Y_STEP_TGT, 32'h000003E8);
		wr(`OFS_START_CTRL, 32'h00000000);
		wr(`OFS_CMD, 32'h00000000);
		yBase = yCnt;
		wr(`OFS_CMD, 32'h00000008);
		idle(20);
		wr(`OFS_CMD, 32'h0000000A);
		ySw = yCnt;
		idle(3);
		check("y speed after switch", {ySpd, yPos}, 2'b10);
		wr(`OFS_CMD, 32'h0000000A);
		idle(3);
		check("y held request", {ySpd, yErr}, 2'b10);
		idle(20);
		wr(`OFS_CMD, 32'h0000001A);
		idle(3);
		check("y motion went on", {yDir, (yCnt - ySw) > 32'h00000003}, 2'b01);
		rdChk("y position kept", `OFS_Y_POS, 32'h00000006 + yCnt - yBase);
		$display("y switches done");
		wr(`OFS_START_CTRL, 32'h00000003);
		wr(`OFS_AXIS, `AXIS_X_CODE);
		wr(`OFS_CMD, 32'h00000000);
		wr(`OFS_CMD, 32'h00000008);
		for (int i = 0; i < 2; i++) begin
			wr(`OFS_AXIS, i ? 32'h00000000 : 32'h00000002);
			wr(`OFS_SLOT, i ? 32'h00000001 : 32'h00000000);
			wr(`OFS_CMD, 32'h00000009);
			idle(3);
			check("instruction error", {instrErr, xSpd, xErr}, 3'b110);
			wr(`OFS_STATUS, 32'h00000100);
			check("instruction error cleared", instrErr, 1'b0);
			wr(`OFS_CMD, 32'h00000008);
		end
		wr(`OFS_SLOT, `SLOT_BASE_CODE);
		wr(`OFS_CMD, 32'h0000000A);
		idle(3);
		check("axis error", xErr, 1'b1);
		rdChk("status word", `OFS_STATUS, 32'h00000005);
		// the reverse speed start must show on the direction pin and count the drive down
		ySw = xCnt;
		idle(12);
		check("x reverse steps", {xDir, xCnt < ySw}, 2'b11);
		$display("error cases done");
		wrapUp();
	end
	initial begin
		#1000000;
		check("run time", 32'h1, 32'h0);
		wrapUp();
	end
endmodule // test_axis_control_mode_switch
bind axis_control_mode_switch axis_control_mode_switch_sva chk (.sys_clk(sys_clk), .reset_n(reset_n),
	.regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData),
	.xSpeedCtrlFlag(xSpeedCtrlFlag), .ySpeedCtrlFlag(ySpeedCtrlFlag), .xPositionCtrlFlag(xPositionCtrlFlag),
	.yPositionCtrlFlag(yPositionCtrlFlag), .xAxisErrorFlag(xAxisErrorFlag),
	.yAxisErrorFlag(yAxisErrorFlag), .instrErrorFlag(instrErrorFlag), .irq(irq));
`default_nettype wire
